// >>> logic/pmc_pkg.sv
// Package for the power-mode controller: register addresses, field
// positions, reset values and the mode enumeration.
// Assumes an 8-bit special-function-register bus on the CPU side.
`default_nettype none
package pmc_pkg;
  // ------------------------------------------------------------------
  // Register addresses and layout
  // ------------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_REGULATOR_CONTROL  = 8'hC9;
  localparam int         BIT_IDLE_SELECT         = 0;
  localparam int         BIT_STOP_SELECT         = 1;
  localparam int         BIT_STOP_CONFIG         = 3;
  localparam int         FLAGS_LSB               = 2;
  localparam int         FLAGS_WIDTH             = 6;
  localparam logic [5:0] FLAGS_RESET             = 6'h00;
  localparam logic [7:0] READ_ZERO               = 8'h00;
  localparam logic       STOP_CONFIG_RESET       = 1'b0;

  // ------------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMC_RUN,
    PMC_IDLE,
    PMC_STOP
  } pmc_mode_type;
endpackage
`default_nettype wire

// >>> logic/pmc_wake_filter.sv
// Reset-source gate: decides which reset sources may end a power mode.
// Assumes all reset requests are already synchronous to sys_clk.
`default_nettype none
module pmc_wake_filter (
  // Configuration and mode
  input  wire logic inStop,
  input  wire logic regulatorOff,
  // Reset sources
  input  wire logic pinReset,
  input  wire logic watchdogReset,
  input  wire logic missingClockReset,
  input  wire logic otherReset,
  // Result
  output logic      anyReset
);
  logic internalReset;

  assign internalReset = watchdogReset | missingClockReset | otherReset;

  // With the regulator shut down in stop, internal sources have no
  // supply, so only the pin can end stop.
  assign anyReset = pinReset |
                    (internalReset & ~(inStop & regulatorOff));
endmodule
`default_nettype wire

// >>> logic/pmc_power_mode_control.sv
// Power-mode controller: holds the power control and regulator control
// registers and runs the idle and stop modes of the CPU.
// Assumes a CPU core that reports instruction completion and obeys halt.
// What this block does
// - Setting idle select halts the CPU after the writing instruction ends.
// - In idle, registers and memory hold; peripherals and clocks run.
// - An enabled interrupt in idle clears idle and restarts the CPU.
// - After the interrupt returns, execution resumes after the idle write.
// - A reset in idle performs a normal reset from address zero.
// - An enabled watchdog runs in idle and its reset ends idle.
// - Setting stop select enters stop after the writing instruction ends.
// - Stop halts oscillator, CPU, digital peripherals, timers, interrupts.
// - Only a reset ends stop; interrupts never wake it.
// - An enabled missing clock detector reset ends stop.
// - Stop config 0 keeps regulator on; 1 allows only pin reset.
// - Idle and stop select bits always read as zero.
// - Bits 7 to 2 are plain software flags, cleared at reset.
`default_nettype none
module pmc_power_mode_control (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // Register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrite,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regRead,
  output logic      [7:0] regReadData,
  // CPU core
  input  wire logic       instrDone,
  input  wire logic       interruptPending,
  output logic            cpuHalt,
  output logic            oscStop,
  output logic            periphClockStop,
  output logic            regulatorShutdown,
  // Reset sources
  input  wire logic       pinReset,
  input  wire logic       watchdogReset,
  input  wire logic       missingClockReset,
  input  wire logic       otherReset,
  output logic            deviceReset
);
  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  pmc_pkg::pmc_mode_type modeQ;
  logic [5:0] flagsQ;
  logic       stopConfigQ;
  logic       idleReqQ;
  logic       stopReqQ;
  logic       wakeReset;
  logic       pcWrite;
  logic       rcWrite;

  assign pcWrite = regWrite && (regAddr == pmc_pkg::ADDR_POWER_MODE_CONTROL);
  assign rcWrite = regWrite && (regAddr == pmc_pkg::ADDR_REGULATOR_CONTROL);

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flagsQ <= pmc_pkg::FLAGS_RESET;
    end else if (pcWrite) begin
      flagsQ <= regWriteData[pmc_pkg::FLAGS_LSB +:
                             pmc_pkg::FLAGS_WIDTH];
    end
  end

  // Reserved regulator bits are not stored; software keeps them at reset.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stopConfigQ <= pmc_pkg::STOP_CONFIG_RESET;
    end else if (rcWrite) begin
      stopConfigQ <= regWriteData[pmc_pkg::BIT_STOP_CONFIG];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regReadData <= pmc_pkg::READ_ZERO;
    end else if (regRead) begin
      if (regAddr == pmc_pkg::ADDR_POWER_MODE_CONTROL) begin
        regReadData <= {flagsQ, 2'b00};
      end else if (regAddr == pmc_pkg::ADDR_REGULATOR_CONTROL) begin
        regReadData <= {4'h0, stopConfigQ, 3'h0};
      end else begin
        regReadData <= pmc_pkg::READ_ZERO;
      end
    end
  end

  // ------------------------------------------------------------------
  // Mode requests and the mode machine
  // ------------------------------------------------------------------
  // A request waits for the writing instruction to retire; stop wins if
  // both select bits are written together.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      idleReqQ <= 1'b0;
      stopReqQ <= 1'b0;
    end else if (pcWrite) begin
      idleReqQ <= regWriteData[pmc_pkg::BIT_IDLE_SELECT];
      stopReqQ <= regWriteData[pmc_pkg::BIT_STOP_SELECT];
    end else if (instrDone) begin
      idleReqQ <= 1'b0;
      stopReqQ <= 1'b0;
    end
  end

  pmc_wake_filter uWake (
    .inStop            (modeQ == pmc_pkg::PMC_STOP),
    .regulatorOff      (stopConfigQ),
    .pinReset          (pinReset),
    .watchdogReset     (watchdogReset),
    .missingClockReset (missingClockReset),
    .otherReset        (otherReset),
    .anyReset          (wakeReset)
  );

  // Resets leave through deviceReset; the wake reset itself returns the
  // mode to run in the same cycle so the CPU restarts from address zero.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeQ <= pmc_pkg::PMC_RUN;
    end else begin
      case (modeQ)
        pmc_pkg::PMC_RUN: begin
          if (instrDone && stopReqQ) begin
            modeQ <= pmc_pkg::PMC_STOP;
          end else if (instrDone && idleReqQ) begin
            modeQ <= pmc_pkg::PMC_IDLE;
          end
        end
        pmc_pkg::PMC_IDLE: begin
          // Clearing the mode on an interrupt resumes the held program counter; a wake reset restarts from address zero.
          if (wakeReset) begin
            modeQ <= pmc_pkg::PMC_RUN;
          end else if (interruptPending) begin
            modeQ <= pmc_pkg::PMC_RUN;
          end
        end
        pmc_pkg::PMC_STOP: begin
          if (wakeReset) begin
            modeQ <= pmc_pkg::PMC_RUN;
          end
        end
        default: modeQ <= pmc_pkg::PMC_RUN;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Idle gates only the CPU clock; peripherals and clocks run on.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuHalt           <= 1'b0;
      oscStop           <= 1'b0;
      periphClockStop   <= 1'b0;
      regulatorShutdown <= 1'b0;
      deviceReset       <= 1'b0;
    end else begin
      cpuHalt         <= (modeQ != pmc_pkg::PMC_RUN) && !wakeReset &&
                         !((modeQ == pmc_pkg::PMC_IDLE) &&
                           interruptPending);
      oscStop         <= (modeQ == pmc_pkg::PMC_STOP) && !wakeReset;
      periphClockStop <= (modeQ == pmc_pkg::PMC_STOP) && !wakeReset;
      regulatorShutdown <= (modeQ == pmc_pkg::PMC_STOP) && stopConfigQ &&
                           !wakeReset;
      deviceReset     <= wakeReset;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Wake events may be one-cycle pulses, so the halt check looks at the
  // events of the cycle that launched the halt output.
  property p_idle_entry;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_RUN && instrDone && idleReqQ && !stopReqQ)
      |=> (modeQ == pmc_pkg::PMC_IDLE)
          ##1 (cpuHalt || $past(interruptPending) || $past(wakeReset));
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle missed");

  property p_stop_entry;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_RUN && instrDone && stopReqQ)
      |=> modeQ == pmc_pkg::PMC_STOP;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop missed");

  property p_idle_irq_wake;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_IDLE && interruptPending)
      |=> modeQ == pmc_pkg::PMC_RUN ##0 !cpuHalt;
  endproperty
  a_idle_irq_wake: assert property (p_idle_irq_wake)
    else $error("no wake");

  property p_stop_irq_ignored;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_STOP && !wakeReset)
      |=> modeQ == pmc_pkg::PMC_STOP;
  endproperty
  a_stop_irq_ignored: assert property (p_stop_irq_ignored)
    else $error("stop left");

  property p_reset_out;
    @(posedge sys_clk) disable iff (sys_rst)
      wakeReset |=> deviceReset && !cpuHalt;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("reset lost");

  property p_pin_only;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_STOP && stopConfigQ && !pinReset)
      |=> !deviceReset;
  endproperty
  a_pin_only: assert property (p_pin_only)
    else $error("gated reset");

  property p_mcd_wakes;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_STOP && !stopConfigQ && missingClockReset)
      |=> deviceReset && modeQ == pmc_pkg::PMC_RUN;
  endproperty
  a_mcd_wakes: assert property (p_mcd_wakes)
    else $error("mcd ignored");

  property p_read_zero;
    @(posedge sys_clk) disable iff (sys_rst)
      (regRead && regAddr == pmc_pkg::ADDR_POWER_MODE_CONTROL)
      |=> regReadData[1:0] == 2'b00 && regReadData[7:2] == $past(flagsQ);
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("bad read");

  property p_stop_outputs;
    @(posedge sys_clk) disable iff (sys_rst)
      (modeQ == pmc_pkg::PMC_STOP && !wakeReset)
      |=> oscStop && periphClockStop && cpuHalt;
  endproperty
  a_stop_outputs: assert property (p_stop_outputs)
    else $error("stop leak");

  c_idle: cover property (@(posedge sys_clk) modeQ == pmc_pkg::PMC_IDLE
                          ##1 modeQ == pmc_pkg::PMC_RUN);
  c_stop: cover property (@(posedge sys_clk) modeQ == pmc_pkg::PMC_STOP
                          ##1 deviceReset);
  c_cfg: cover property (@(posedge sys_clk) regulatorShutdown);
endmodule
`default_nettype wire

// >>> test/pmc_cpu_model.sv
// Partner model: a CPU core that reports instruction completion.
// Assumes clock and reset are shared with the power-mode controller.
`default_nettype none
module pmc_cpu_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Core control
  input  wire logic step,
  input  wire logic cpuHalt,
  output logic      instrDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // Each step with cpuHalt low ends one instruction one cycle later; a step while
  // cpuHalt is high ends no instruction.
  // The core is assumed to run from the internal oscillator.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst)
      instrDone <= 1'b0;
    else
      instrDone <= step & ~cpuHalt;
  end
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the power-mode controller.
// deviceReset is only checked; the bench drives sys_rst itself through do_reset.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       step = 1'b0;
  logic       interruptPending = 1'b0;
  logic [3:0] src = 4'h0;
  logic       instrDone, cpuHalt, oscStop, periphClockStop;
  logic       regulatorShutdown, deviceReset;
  logic [7:0] regReadData, outs;
  int         num_errors = 0, checks = 0, expFlags = 0, expCfg = 0;
  assign outs = {3'h0, deviceReset, cpuHalt, oscStop, periphClockStop,
                 regulatorShutdown};
  always #5 sys_clk = ~sys_clk;
  pmc_power_mode_control uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrite(regWrite), .regWriteData(regWriteData),
    .regRead(regRead), .regReadData(regReadData), .instrDone(instrDone),
    .interruptPending(interruptPending), .cpuHalt(cpuHalt),
    .oscStop(oscStop), .periphClockStop(periphClockStop),
    .regulatorShutdown(regulatorShutdown), .pinReset(src[0]),
    .watchdogReset(src[1]), .missingClockReset(src[2]),
    .otherReset(src[3]), .deviceReset(deviceReset));
  pmc_cpu_model cpu (.sys_clk(sys_clk), .sys_rst(sys_rst), .step(step),
    .cpuHalt(cpuHalt), .instrDone(instrDone));
  // ------------------------------------------------------------------
  // Bench model and bus tasks
  // ------------------------------------------------------------------
  task automatic cmp(input string name, input logic [7:0] exp, got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmp_outs(input logic [7:0] exp);
    checks++;
    if (outs !== exp) begin
      num_errors++;
      $display("mismatch outs expected %h seen %h", exp, outs);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a);
    logic [7:0] e;
    e = (a == 8'h87) ? {expFlags[5:0], 2'b00} :
        (a == 8'hC9) ? {4'h0, expCfg[0], 3'h0} : 8'h00;
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1;
    cmp("read", e, regReadData);
  endtask
  task automatic enter(input logic [7:0] d);
    wr(8'h87, d);
    expFlags = d[7:2];
    #1;
    cmp_outs(8'h00);
    @(posedge sys_clk);
    step <= 1'b1;
    @(posedge sys_clk);
    step <= 1'b0;
    tick(4);
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    src <= 4'h0;
    interruptPending <= 1'b0;
    tick(4);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    expFlags = 0;
    expCfg = 0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] r, e;
    void'($urandom(32'h89BD));
    do_reset();
    #1;
    cmp_outs(8'h00);
    // Select bits are written at random too; with no instruction retired
    // they must neither halt the core nor read back.
    repeat (4) begin
      r = 8'($urandom);
      wr(8'h87, r);
      expFlags = r[7:2];
      wr(8'hC9, {4'h0, r[3], 3'h0});
      expCfg = r[3];
      chk(8'h87);
      chk(8'hC9);
      chk(8'($urandom));
      cmp_outs(8'h00);
    end
    do_reset();
    for (int s = 0; s < 5; s++) begin
      r = 8'($urandom);
      enter({r[7:2], 2'b01});
      cmp_outs(8'h08);
      chk(8'h87);
      @(posedge sys_clk);
      if (s == 4) begin
        interruptPending <= 1'b1;
        tick(2);
        cmp_outs(8'h00);
        chk(8'h87);
      end else begin
        src <= 4'h1 << s;
        tick(2);
        cmp_outs(8'h10);
      end
      do_reset();
    end
    // Odd passes write both select bits; stop must win.
    for (int c = 0; c < 2; c++) begin
      for (int s = 0; s < 4; s++) begin
        wr(8'hC9, c[0] ? 8'h08 : 8'h00);
        expCfg = c;
        enter({6'h00, 1'b1, s[0]});
        e = c[0] ? 8'h0F : 8'h0E;
        cmp_outs(e);
        chk(8'h87);
        chk(8'hC9);
        @(posedge sys_clk);
        interruptPending <= 1'b1;
        tick(3);
        cmp_outs(e);
        @(posedge sys_clk);
        src <= 4'h1 << s;
        tick(2);
        cmp_outs((c == 0 || s == 0) ? 8'h10 : e);
        do_reset();
      end
    end
    tally_and_finish();
  end
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
